// >>> rtl/asr_defines.svh
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// Register offsets on the register port.
`define ASR_OFS_CTRL_A 8'h12
`define ASR_OFS_CTRL_B 8'h13
`define ASR_OFS_RT_CH0_LO 8'h17
`define ASR_OFS_RT_CH0_HI 8'h18
`define ASR_OFS_RT_CH8_LO 8'h27
`define ASR_OFS_RT_CH8_HI 8'h28
`define ASR_OFS_RT_CH12_LO 8'h2F
`define ASR_OFS_RT_CH12_HI 8'h30
`define ASR_OFS_GP_CH0_LO 8'h37
`define ASR_OFS_GP_CH0_HI 8'h38
`define ASR_OFS_GP_CH8_LO 8'h47
`define ASR_OFS_GP_CH8_HI 8'h48
`define ASR_OFS_GP_CH12_LO 8'h4F
`define ASR_OFS_GP_CH12_HI 8'h50

// Field positions in both control and status registers.
`define ASR_BIT_BUSY 0
`define ASR_BIT_SW_DONE 1
`define ASR_BIT_RT_DONE 2
`define ASR_BIT_RSVD 3
`define ASR_BIT_USB_DONE 4
`define ASR_BIT_START 5
`define ASR_BIT_USB_THR 6
`define ASR_BIT_BAT_THR 7

// Reset values.
`define ASR_RST_DONE 1'b1
`define ASR_RST_BUSY 1'b0
`define ASR_RST_THR 1'b1
`define ASR_RST_RESULT 10'h000

`endif

// >>> rtl/asr_pkg.sv
package asr_pkg;

  // One bit per conversion sequence kind.
  typedef struct packed {
    logic chg;
    logic usb;
    logic sw_b;
    logic sw_a;
    logic rt;
  } asr_seq_t;

  // Result bank selection.
  typedef enum logic [0:0] {
    ASR_BANK_RT = 1'b0,
    ASR_BANK_GP = 1'b1
  } asr_bank_t;

  // Channel selection inside a bank.
  typedef enum logic [1:0] {
    ASR_CH0 = 2'b00,
    ASR_CH8 = 2'b01,
    ASR_CH12 = 2'b10
  } asr_chan_t;

  // One converted sample delivered by the converter core.
  typedef struct packed {
    logic valid;
    asr_bank_t bank;
    asr_chan_t chan;
    logic [9:0] data;
  } asr_result_t;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asr_reg_req_t;

endpackage : asr_pkg

// >>> rtl/asr_top.sv
// Function
// - Real-time done flag is 0 while running, 1 at finish, 1 after reset.
// - Each finished real-time, software or USB sequence raises an interrupt request.
// - First software done flag is 0 while running, 1 at finish, reset 1.
// - Second software done flag, bit 1, is 0 while running, 1 at finish.
// - USB done flag, bit 4, is 0 while running, 1 at finish, reset 1.
// - Busy, bit 0, is 1 while any sequence runs, else 0; reset 0.
// - Busy, shared done flags and comparator bits are single elements in both registers.
// - Writing 1 to bit 5 of the second register starts sequence B; 0 ignored.
// - Charger done flag is 0 while running; at finish set it and signal data ready.
// - Bit 7 shows battery above battery threshold; read-only, reset 1.
// - Bit 6 shows battery above USB threshold; read-only, reset 1.
// - Two result LSBs sit in bits 7:6 of the low register, reset 0.
// - Eight result MSBs sit in the high register, read-only, reset 0x00.
// - Bits 5:0 of every low result register read as zero.
// - Real-time bank holds channels 0, 8 and 12 from offset 0x17.
// - Separate general-purpose bank holds channels 0, 8 and 12 from 0x37.
// - Writing 1 to bit 5 of the first register starts sequence A; 0 ignored.
// - New settling time applies only while no conversion runs.
`timescale 1ns/100ps
`include "asr_defines.svh"

module asr_top
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire asr_pkg::asr_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire asr_pkg::asr_seq_t seq_begin,
  input wire asr_pkg::asr_seq_t seq_end,
  input wire asr_pkg::asr_result_t result_in,
  input wire logic battery_threshold_above,
  input wire logic usb_threshold_above,
  output logic software_seq_a_start,
  output logic software_seq_b_start,
  output logic [3:0] seq_irq_req,
  output logic charger_data_ready,
  output logic charger_seq_done,
  output logic settle_write_allowed
);
  import asr_pkg::*;

  // Interface overview. The register port is the parallel side of the serial
  // slave; it presents one request per cycle and expects read data one cycle
  // after a taken read. The converter core reports sequence begins and ends
  // as one-cycle pulses, and delivers each finished sample on result_in.
  // Everything below is frozen while clk_en is low, except reset, which acts
  // on every edge so that a stalled clock gate cannot keep stale flags alive.
  // Flag polarity matters to software: a done flag is 1 when idle and drops
  // to 0 while its sequence runs, so a poll loop waits for a 1, never a 0.
  // Busy is the opposite and is the single source for the settling gate.

  // Low result register: two LSBs on top, zeros below.
  function automatic logic [7:0] asr_low_byte(input logic [9:0] value);
    asr_low_byte = {value[1:0], 6'h00};
  endfunction : asr_low_byte

  // High result register: the eight MSBs.
  function automatic logic [7:0] asr_high_byte(input logic [9:0] value);
    asr_high_byte = value[9:2];
  endfunction : asr_high_byte

  // The comparators are free-running analog outputs with no relation to
  // core_clk. Two flip-flops bound the chance of a metastable value reaching
  // the read path; the price is two cycles of lag, which software cannot see
  // because it polls far more slowly than that.
  // Comparator outputs come from the analog side, so they are synchronised.
  logic bat_sync1_reg;
  logic bat_sync2_reg;
  logic usb_sync1_reg;
  logic usb_sync2_reg;
  logic bat_sync1_next;
  logic bat_sync2_next;
  logic usb_sync1_next;
  logic usb_sync2_next;

  always_comb
  begin
    bat_sync1_next = bat_sync1_reg;
    bat_sync2_next = bat_sync2_reg;
    usb_sync1_next = usb_sync1_reg;
    usb_sync2_next = usb_sync2_reg;
    if (rst)
    begin
      bat_sync1_next = `ASR_RST_THR;
      bat_sync2_next = `ASR_RST_THR;
      usb_sync1_next = `ASR_RST_THR;
      usb_sync2_next = `ASR_RST_THR;
    end
    else if (clk_en)
    begin
      bat_sync1_next = battery_threshold_above;
      bat_sync2_next = bat_sync1_reg;
      usb_sync1_next = usb_threshold_above;
      usb_sync2_next = usb_sync1_reg;
    end
  end

  // Synchroniser registers.
  always_ff @(posedge core_clk)
  begin
    bat_sync1_reg <= bat_sync1_next;
    bat_sync2_reg <= bat_sync2_next;
    usb_sync1_reg <= usb_sync1_next;
    usb_sync2_reg <= usb_sync2_next;
  end

  // A write that carries 0 in the start bit is harmless by design, so
  // software may write back a value it has just read without launching a
  // conversion.
  // Start writes: only a 1 in the start bit of the matching register counts.
  logic start_a_wr;
  logic start_b_wr;

  assign start_a_wr = reg_req.wr && (reg_req.addr == `ASR_OFS_CTRL_A) &&
                      reg_req.wdata[`ASR_BIT_START];
  assign start_b_wr = reg_req.wr && (reg_req.addr == `ASR_OFS_CTRL_B) &&
                      reg_req.wdata[`ASR_BIT_START];

  // Sequence flags: one done bit per sequence kind plus one shared busy bit.
  asr_seq_t done_reg;
  asr_seq_t done_next;
  logic busy_reg;
  logic busy_next;
  logic start_a_reg;
  logic start_a_next;
  logic start_b_reg;
  logic start_b_next;
  logic [3:0] irq_reg;
  logic [3:0] irq_next;
  logic chg_ready_reg;
  logic chg_ready_next;
  asr_seq_t clear_mask;

  // A software start clears its done flag at once, so that a poll right after
  // the write never sees the stale 1 of the previous run. An end that lands in
  // the same cycle as a begin or a start still wins and sets the flag.
  always_comb
  begin
    clear_mask = seq_begin;
    clear_mask.sw_a = seq_begin.sw_a | start_a_wr;
    clear_mask.sw_b = seq_begin.sw_b | start_b_wr;
    done_next = done_reg;
    busy_next = busy_reg;
    start_a_next = start_a_reg;
    start_b_next = start_b_reg;
    irq_next = irq_reg;
    chg_ready_next = chg_ready_reg;
    if (rst)
    begin
      done_next = {5{`ASR_RST_DONE}};
      busy_next = `ASR_RST_BUSY;
      start_a_next = 1'b0;
      start_b_next = 1'b0;
      irq_next = 4'h0;
      chg_ready_next = 1'b0;
    end
    else if (clk_en)
    begin
      done_next = (done_reg & ~clear_mask) | seq_end;
      busy_next = ~&done_next;
      start_a_next = start_a_wr;
      start_b_next = start_b_wr;
      irq_next = {seq_end.usb, seq_end.sw_b, seq_end.sw_a, seq_end.rt};
      chg_ready_next = seq_end.chg;
    end
  end

  // Interrupt requests are bare pulses; masking, edge selection and status
  // latching belong to the interrupt handler that sits beside this block.
  // Sequence flag registers.
  always_ff @(posedge core_clk)
  begin
    done_reg <= done_next;
    busy_reg <= busy_next;
    start_a_reg <= start_a_next;
    start_b_reg <= start_b_next;
    irq_reg <= irq_next;
    chg_ready_reg <= chg_ready_next;
  end

  // Outputs come straight from flip-flops, so downstream logic sees clean
  // pulses and levels with no decode glitches.
  assign software_seq_a_start = start_a_reg;
  assign software_seq_b_start = start_b_reg;
  assign seq_irq_req = irq_reg;
  assign charger_data_ready = chg_ready_reg;
  assign charger_seq_done = done_reg.chg;

  // The settling-time register lives elsewhere; it may only take a new value
  // while nothing converts, and this level is its write gate.
  assign settle_write_allowed = ~busy_reg;

  // The banks are kept as plain registers rather than a memory macro because
  // every entry must be readable in the same cycle as its neighbour, and the
  // table is only six words deep.
  // Result banks: index 0 is the real-time bank, index 1 the general one.
  logic [9:0] result_reg [2][3];
  logic [9:0] result_next [2][3];

  // A sample is stored on the edge it arrives. The converter reports a
  // sequence end no earlier than its last sample, so the value is already
  // in place when the done flag rises.
  always_comb
  begin
    result_next = result_reg;
    if (rst)
    begin
      for (int b = 0; b < 2; b++)
      begin
        for (int c = 0; c < 3; c++)
        begin
          result_next[b][c] = `ASR_RST_RESULT;
        end
      end
    end
    else if (clk_en && result_in.valid && (result_in.chan != 2'b11))
    begin
      result_next[result_in.bank][result_in.chan] = result_in.data;
    end
  end

  // Result bank registers.
  always_ff @(posedge core_clk)
  begin
    result_reg <= result_next;
  end

  // Because the shared bits are taken from one flop each, the two control
  // registers can never disagree about busy, the shared done flags or the
  // comparator state, whatever order software reads them in.
  // Status byte shared by both control registers; only the sequence done
  // bit differs. Bit 3 is reserved and reads as 1.
  logic [7:0] ctrl_common;

  always_comb
  begin
    ctrl_common = 8'h00;
    ctrl_common[`ASR_BIT_BAT_THR] = bat_sync2_reg;
    ctrl_common[`ASR_BIT_USB_THR] = usb_sync2_reg;
    ctrl_common[`ASR_BIT_USB_DONE] = done_reg.usb;
    ctrl_common[`ASR_BIT_RSVD] = 1'b1;
    ctrl_common[`ASR_BIT_RT_DONE] = done_reg.rt;
    ctrl_common[`ASR_BIT_BUSY] = busy_reg;
  end

  // Reads have no side effects: nothing is cleared on read, so software may
  // poll a control register as often as it likes without losing an event.
  // The two result bytes of a channel are not latched against each other; a
  // sample that lands between the two reads can tear the 10-bit value, so
  // software should read both bytes only after the done flag has risen.
  // Read decode. The start bit is write-only and reads 0; unmapped offsets
  // read 0.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] rd_value;

  always_comb
  begin
    rd_value = 8'h00;
    unique case (reg_req.addr)
      `ASR_OFS_CTRL_A:
      begin
        rd_value = ctrl_common;
        rd_value[`ASR_BIT_SW_DONE] = done_reg.sw_a;
      end
      `ASR_OFS_CTRL_B:
      begin
        rd_value = ctrl_common;
        rd_value[`ASR_BIT_SW_DONE] = done_reg.sw_b;
      end
      `ASR_OFS_RT_CH0_LO: rd_value = asr_low_byte(result_reg[0][0]);
      `ASR_OFS_RT_CH0_HI: rd_value = asr_high_byte(result_reg[0][0]);
      `ASR_OFS_RT_CH8_LO: rd_value = asr_low_byte(result_reg[0][1]);
      `ASR_OFS_RT_CH8_HI: rd_value = asr_high_byte(result_reg[0][1]);
      `ASR_OFS_RT_CH12_LO: rd_value = asr_low_byte(result_reg[0][2]);
      `ASR_OFS_RT_CH12_HI: rd_value = asr_high_byte(result_reg[0][2]);
      `ASR_OFS_GP_CH0_LO: rd_value = asr_low_byte(result_reg[1][0]);
      `ASR_OFS_GP_CH0_HI: rd_value = asr_high_byte(result_reg[1][0]);
      `ASR_OFS_GP_CH8_LO: rd_value = asr_low_byte(result_reg[1][1]);
      `ASR_OFS_GP_CH8_HI: rd_value = asr_high_byte(result_reg[1][1]);
      `ASR_OFS_GP_CH12_LO: rd_value = asr_low_byte(result_reg[1][2]);
      `ASR_OFS_GP_CH12_HI: rd_value = asr_high_byte(result_reg[1][2]);
      default: rd_value = 8'h00;
    endcase
    rdata_next = rdata_reg;
    if (rst)
    begin
      rdata_next = 8'h00;
    end
    else if (clk_en && reg_req.rd)
    begin
      rdata_next = rd_value;
    end
  end

  // Read data register; it holds until the next read.
  always_ff @(posedge core_clk)
  begin
    rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

endmodule : asr_top

// >>> tb/asr_top_asserts.sv
`timescale 1ns/100ps
`include "asr_defines.svh"

module asr_top_asserts
  import asr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire asr_pkg::asr_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire asr_pkg::asr_seq_t seq_begin,
  input wire asr_pkg::asr_seq_t seq_end,
  input wire asr_pkg::asr_result_t result_in,
  input wire logic battery_threshold_above,
  input wire logic usb_threshold_above,
  input wire logic software_seq_a_start,
  input wire logic software_seq_b_start,
  input wire logic [3:0] seq_irq_req,
  input wire logic charger_data_ready,
  input wire logic charger_seq_done,
  input wire logic settle_write_allowed
);
  // One clock domain, so reset masks every check from here.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // A taken write carrying the start bit to one control register.
  sequence s_go(logic [7:0] ofs);
    clk_en && reg_req.wr && reg_req.addr == ofs && reg_req.wdata[`ASR_BIT_START];
  endsequence

  // A taken write whose start bit is clear must launch nothing.
  sequence s_nogo;
    clk_en && reg_req.wr && !reg_req.wdata[`ASR_BIT_START];
  endsequence

  AST_START_A: assert property (s_go(`ASR_OFS_CTRL_A) |=> software_seq_a_start)
    else $error("start A pulse missing");
  AST_START_B: assert property (s_go(`ASR_OFS_CTRL_B) |=> software_seq_b_start)
    else $error("start B pulse missing");
  AST_NO_START: assert property (s_nogo |=> !software_seq_a_start && !software_seq_b_start)
    else $error("start pulse from a zero write");
  AST_IRQ_RT: assert property (clk_en && seq_end.rt |=> seq_irq_req[0])
    else $error("real-time interrupt missing");
  AST_IRQ_USB: assert property (clk_en && seq_end.usb |=> seq_irq_req[3])
    else $error("usb interrupt missing");
  AST_IRQ_CAUSE: assert property (seq_irq_req[1] |-> $past(seq_end.sw_a))
    else $error("sequence A interrupt without an end");
  AST_CHG_END: assert property (clk_en && seq_end.chg |=> charger_data_ready && charger_seq_done)
    else $error("charger completion not signalled");
  AST_CHG_RUN: assert property (clk_en && seq_begin.chg && !seq_end.chg |=> !charger_seq_done)
    else $error("charger done high while running");
  AST_SETTLE: assert property (clk_en && seq_begin.rt && !seq_end.rt |=> !settle_write_allowed)
    else $error("settling write allowed while busy");
endmodule : asr_top_asserts

bind asr_top asr_top_asserts u_chk (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .seq_begin(seq_begin), .seq_end(seq_end),
  .result_in(result_in), .battery_threshold_above(battery_threshold_above),
  .usb_threshold_above(usb_threshold_above), .software_seq_a_start(software_seq_a_start),
  .software_seq_b_start(software_seq_b_start), .seq_irq_req(seq_irq_req),
  .charger_data_ready(charger_data_ready), .charger_seq_done(charger_seq_done),
  .settle_write_allowed(settle_write_allowed));

// >>> tb/asr_conv_model.sv
`timescale 1ns/100ps

module asr_conv_model
  import asr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start_a,
  input wire logic start_b,
  input wire asr_pkg::asr_seq_t req,
  input wire asr_pkg::asr_result_t res,
  input wire logic [3:0] dly,
  output asr_pkg::asr_seq_t seq_begin,
  output asr_pkg::asr_seq_t seq_end,
  output asr_pkg::asr_result_t result_in
);
  asr_seq_t run;
  asr_seq_t go;
  logic [3:0] cnt;

  assign go = req | asr_seq_t'({2'b00, start_b, start_a, 1'b0});

  // One sequence at a time; idle data is inverted so stale values never look valid.
  always @(posedge core_clk)
  begin
    seq_begin <= '0;
    seq_end <= '0;
    result_in <= {1'b0, ~res[12:0]};
    if (rst)
      run <= '0;
    else if (run == '0)
    begin
      run <= go;
      seq_begin <= go;
      cnt <= dly;
    end
    else if (cnt == 4'h0)
    begin
      seq_end <= run;
      result_in <= res;
      run <= '0;
    end
    else
      cnt <= cnt - 4'h1;
  end
endmodule : asr_conv_model

// >>> tb/asr_top_tb.sv
`timescale 1ns/100ps

module asr_top_tb;
  import asr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic bat_thr = 1'b1;
  logic usb_thr = 1'b1;
  asr_reg_req_t req = '0;
  asr_seq_t trig = '0;
  asr_result_t res = '0;
  logic [7:0] reg_rdata;
  logic sa;
  logic sb;
  logic chg_done;
  asr_seq_t sbeg;
  asr_seq_t send;
  asr_result_t rin;
  logic [7:0] exq[$];
  logic [9:0] sh[6];
  logic [7:0] lo[6] = '{8'h17, 8'h27, 8'h2F, 8'h37, 8'h47, 8'h4F};
  logic [4:0] dn = 5'h1F;
  logic rd_d = 1'b0;
  logic [3:0] irq;
  logic drdy;
  logic swa;
  int irq_cnt[5] = '{default: 0};
  int exp_cnt[5] = '{default: 0};
  int miscompares = 0;
  int n_tests = 0;

  always #12.5 core_clk = ~core_clk;

  asr_top uut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_req(req),
    .reg_rdata(reg_rdata), .seq_begin(sbeg), .seq_end(send), .result_in(rin),
    .battery_threshold_above(bat_thr), .usb_threshold_above(usb_thr),
    .software_seq_a_start(sa), .software_seq_b_start(sb), .seq_irq_req(irq),
    .charger_data_ready(drdy), .charger_seq_done(chg_done), .settle_write_allowed(swa));
  asr_conv_model model (.core_clk(core_clk), .rst(rst), .start_a(sa), .start_b(sb),
    .req(trig), .res(res), .dly(4'hA), .seq_begin(sbeg), .seq_end(send), .result_in(rin));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // One access per call; the gap cycle keeps strobes from merging.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    req <= '0;
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rd

  function automatic logic [7:0] st(input logic b);
    return {bat_thr, usb_thr, 1'b0, dn[3], 1'b1, dn[0], b ? dn[2] : dn[1], ~&dn};
  endfunction : st

  task automatic rd_all;
    for (int i = 0; i < 6; i++)
    begin
      rd(lo[i], {sh[i][1:0], 6'h00});
      rd(lo[i] + 8'h01, sh[i][9:2]);
    end
  endtask : rd_all

  // Runs one sequence of kind k (bit of the sequence struct) and checks flags and results.
  task automatic seqr(input int k);
    int i;
    i = $urandom % 6;
    @(posedge core_clk);
    res <= '{valid: 1'b1, bank: asr_bank_t'(i / 3), chan: asr_chan_t'(i % 3),
      data: 10'($urandom)};
    bat_thr <= 1'($urandom);
    usb_thr <= 1'($urandom);
    if (k == 1)
      acc(1'b1, 8'h12, 8'h20 | 8'($urandom));
    else if (k == 2)
      acc(1'b1, 8'h13, 8'h20 | 8'($urandom));
    else
    begin
      trig <= asr_seq_t'(5'h01 << k);
      @(posedge core_clk);
      trig <= '0;
    end
    dn[k] = 1'b0;
    repeat (2) @(posedge core_clk);
    rd(8'h12, st(1'b0));
    rd(8'h13, st(1'b1));
    chk(8'(chg_done), 8'(dn[4]));
    chk(8'(swa), 8'(&dn));
    repeat (16) @(posedge core_clk);
    dn[k] = 1'b1;
    exp_cnt[k]++;
    chk(8'(swa), 8'h01);
    for (int b = 0; b < 5; b++)
      chk(8'(irq_cnt[b]), 8'(exp_cnt[b]));
    sh[i] = res.data;
    rd(8'h12, st(1'b0));
    rd(8'h13, st(1'b1));
    chk(8'(chg_done), 8'h01);
    rd_all;
  endtask : seqr

  // Read answers arrive one cycle after the taken strobe; match them in order.
  always @(posedge core_clk)
  begin
    if (rd_d)
      chk(reg_rdata, exq.pop_front());
    rd_d <= req.rd & clk_en & !rst;
  end

  // Count every completion pulse; index k matches the sequence kind.
  always @(posedge core_clk)
  begin
    for (int b = 0; b < 4; b++)
      if (irq[b] === 1'b1)
        irq_cnt[b]++;
    if (drdy === 1'b1)
      irq_cnt[4]++;
  end

  // Main sequence: reset values, ignored writes, then every sequence kind.
  initial
  begin
    void'($urandom(32'h81C27810));
    foreach (sh[i])
      sh[i] = 10'h000;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h12, 8'hDE);
    rd(8'h13, 8'hDE);
    rd(8'h14, 8'h00);
    acc(1'b1, 8'h12, 8'hDF);
    acc(1'b1, 8'h13, 8'hDF);
    acc(1'b1, 8'h18, 8'hFF);
    rd(8'h12, 8'hDE);
    rd(8'h13, 8'hDE);
    rd_all;
    clk_en <= 1'b0;
    acc(1'b1, 8'h12, 8'h20);
    clk_en <= 1'b1;
    rd(8'h12, 8'hDE);
    for (int j = 0; j < 20; j++)
      seqr(j % 5);
    repeat (4) @(posedge core_clk);
    complete_run;
  end

  // Watchdog: the whole run needs about 1100 cycles.
  initial
  begin
    repeat (8000) @(posedge core_clk);
    miscompares++;
    complete_run;
  end
endmodule : asr_top_tb
